/* rtl/hpsc_top.sv */
// slot capabilities and slot control registers of a switch downstream port
`timescale 1ns/1ps

module hpsc_top #(
  parameter int unsigned BLINK_HALF_CYC = hpsc_pkg::BLINK_HALF_CYC
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite slave
  input  wire logic [hpsc_pkg::ADDR_W-1:0] s_axil_awaddr,
  input  wire logic                        s_axil_awvalid,
  output logic                             s_axil_awready,
  input  wire logic [31:0]                 s_axil_wdata,
  input  wire logic [3:0]                  s_axil_wstrb,
  input  wire logic                        s_axil_wvalid,
  output logic                             s_axil_wready,
  output logic [1:0]                       s_axil_bresp,
  output logic                             s_axil_bvalid,
  input  wire logic                        s_axil_bready,
  input  wire logic [hpsc_pkg::ADDR_W-1:0] s_axil_araddr,
  input  wire logic                        s_axil_arvalid,
  output logic                             s_axil_arready,
  output logic [31:0]                      s_axil_rdata,
  output logic [1:0]                       s_axil_rresp,
  output logic                             s_axil_rvalid,
  input  wire logic                        s_axil_rready,
  // port role and capability overrides
  input  wire logic                        dsp_port,
  input  wire hpsc_pkg::hpsc_ovr_t         smbus_ovr,
  input  wire hpsc_pkg::hpsc_ovr_t         eeprom_ovr,
  // slot hardware events and outputs
  input  wire hpsc_pkg::hpsc_evt_t         hp_evt,
  output logic                             hp_irq,
  output logic                             hp_wake,
  output logic                             attn_led,
  // outgoing message requests
  output logic                             spl_msg_valid,
  output hpsc_pkg::hpsc_spl_t              spl_msg,
  input  wire logic                        spl_msg_ready,
  output logic                             attn_msg_valid,
  output logic [1:0]                       attn_msg,
  input  wire logic                        attn_msg_ready
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  // a zero period would wrap the compare limit, so each blink half would run the whole 32-bit counter range
  if (BLINK_HALF_CYC < 1) begin : g_chk
    $error("hpsc_top: blink half period must be at least one cycle");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    // bus handshakes and answers
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;

    // held write request
    logic                        aw_full;
    logic [hpsc_pkg::ADDR_W-1:0] awaddr;
    logic                        w_full;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;

    // software visible registers
    hpsc_pkg::hpsc_cap_t         cap;
    hpsc_pkg::hpsc_ctl_t         ctl;
    hpsc_pkg::hpsc_sts_t         sts;

    // outputs and message triggers
    logic                        irq;
    logic                        wake;
    logic                        led;
    logic [31:0]                 blink_cnt;
    logic                        spl_send;
    logic                        attn_send;
  } hpsc_top_st_t;

  hpsc_top_st_t        q_r;
  hpsc_top_st_t        q_nxt;
  hpsc_pkg::hpsc_cap_t cap_dflt;
  logic                ovr_load;

  // ------------------------------------------------------------------
  // capability default loader
  // ------------------------------------------------------------------
  hpsc_ovr_load u_ovr (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .smbus_ovr  (smbus_ovr),
    .eeprom_ovr (eeprom_ovr),
    .cap_dflt   (cap_dflt),
    .load       (ovr_load)
  );

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  logic [31:0] wr_mask;
  logic        wr_go;
  logic        wr_cap;
  logic        wr_ctl;
  logic        rd_cap;
  logic        rd_ctl;
  logic        evt_pend;
  logic        wake_pend;

  // byte lanes widened to bit masks
  assign wr_mask = {{8{q_r.wstrb[3]}}, {8{q_r.wstrb[2]}},
                    {8{q_r.wstrb[1]}}, {8{q_r.wstrb[0]}}};

  // a write is carried out once address and data are both held
  // a pending answer blocks a second write
  assign wr_go = q_r.aw_full && q_r.w_full && !q_r.bvalid;

  // the registers answer only on a downstream port
  // address bits 1:0 are ignored
  assign wr_cap = dsp_port && ({q_r.awaddr[7:2], 2'h0} == hpsc_pkg::OFF_SLOT_CAP);
  assign wr_ctl = dsp_port && ({q_r.awaddr[7:2], 2'h0} == hpsc_pkg::OFF_SLOT_CTL);
  assign rd_cap = dsp_port && ({s_axil_araddr[7:2], 2'h0} == hpsc_pkg::OFF_SLOT_CAP);
  assign rd_ctl = dsp_port && ({s_axil_araddr[7:2], 2'h0} == hpsc_pkg::OFF_SLOT_CTL);

  // event gating: status and per-event enable, then the master gate
  assign wake_pend = (q_r.sts.attn_btn  && q_r.ctl.abp_en)
                   | (q_r.sts.pwr_fault && q_r.ctl.pfd_en)
                   | (q_r.sts.pres_chg  && q_r.ctl.pdc_en);
  assign evt_pend  = wake_pend
                   | (q_r.sts.cmd_done  && q_r.ctl.cc_int_en);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    q_nxt           = q_r;
    // message triggers are one-cycle pulses
    q_nxt.spl_send  = 1'b0;
    q_nxt.attn_send = 1'b0;

    // write address and data are taken independently, in either order
    if (s_axil_awvalid && q_r.awready) begin
      q_nxt.aw_full = 1'b1;
      q_nxt.awaddr  = s_axil_awaddr;
    end
    if (s_axil_wvalid && q_r.wready) begin
      q_nxt.w_full = 1'b1;
      q_nxt.wdata  = s_axil_wdata;
      q_nxt.wstrb  = s_axil_wstrb;
    end
    if (q_r.bvalid && s_axil_bready) begin
      q_nxt.bvalid = 1'b0;
    end

    // register write
    // bvalid rises one edge after both halves are held
    if (wr_go) begin
      q_nxt.aw_full = 1'b0;
      q_nxt.w_full  = 1'b0;
      q_nxt.bvalid  = 1'b1;
      q_nxt.bresp   = hpsc_pkg::RESP_OKAY;
      if (wr_cap) begin
        // only the power limit fields take data; all else stays read-only
        q_nxt.cap = hpsc_pkg::hpsc_cap_t'(
                      (q_r.cap & ~(hpsc_pkg::CAP_WR_MASK & wr_mask))
                    | (q_r.wdata & hpsc_pkg::CAP_WR_MASK & wr_mask));
        if (|(hpsc_pkg::CAP_WR_MASK & wr_mask)) begin
          q_nxt.spl_send = 1'b1;
        end
      end else if (wr_ctl) begin
        // enable bits of the low byte
        q_nxt.ctl = hpsc_pkg::hpsc_ctl_t'(
                      (q_r.ctl & ~(hpsc_pkg::CTL_EN_MASK & wr_mask[15:0]))
                    | (q_r.wdata[15:0] & hpsc_pkg::CTL_EN_MASK & wr_mask[15:0]));
        // the reserved indicator code is ignored, so the led never gets an undefined mode
        if (q_r.wstrb[0] && (q_r.wdata[7:6] != hpsc_pkg::ATTN_RSVD)) begin
          q_nxt.ctl.attn_ind_ctl = q_r.wdata[7:6];
          q_nxt.attn_send        = 1'b1;
        end
        // write one to clear on the status half
        q_nxt.sts = hpsc_pkg::hpsc_sts_t'(q_r.sts
                    & ~(q_r.wdata[31:16] & wr_mask[31:16] & hpsc_pkg::STS_W1C_MASK));
      end else begin
        q_nxt.bresp = hpsc_pkg::RESP_SLVERR;
      end
    end

    // loaded defaults land before software looks; they win over a racing write
    // no message on an override, only on software writes
    if (ovr_load) begin
      q_nxt.cap = cap_dflt;
    end

    // events set after the clear so a set in the clearing cycle is kept
    // an upstream port stores no events
    if (dsp_port) begin
      q_nxt.sts.attn_btn  = q_nxt.sts.attn_btn  | hp_evt.attn_btn;
      q_nxt.sts.pwr_fault = q_nxt.sts.pwr_fault | hp_evt.pwr_fault;
      q_nxt.sts.pres_chg  = q_nxt.sts.pres_chg  | hp_evt.pres_chg;
      q_nxt.sts.cmd_done  = q_nxt.sts.cmd_done  | hp_evt.cmd_done;
    end

    // read channel: one read in flight, data registered with the answer
    // rdata is captured once, so it stands under rvalid
    if (q_r.rvalid && s_axil_rready) begin
      q_nxt.rvalid = 1'b0;
    end
    if (s_axil_arvalid && q_r.arready) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp  = hpsc_pkg::RESP_OKAY;
      if (rd_cap) begin
        q_nxt.rdata = q_r.cap & hpsc_pkg::CAP_RD_MASK;
      end else if (rd_ctl) begin
        q_nxt.rdata = {q_r.sts, q_r.ctl};
      end else begin
        q_nxt.rdata = 32'h0000_0000;
        q_nxt.rresp = hpsc_pkg::RESP_SLVERR;
      end
    end

    // interrupt needs status, its enable and the master gate together
    q_nxt.irq  = dsp_port && q_r.ctl.hp_int_en && evt_pend;
    // wakeup follows the per-event enables other than command done, without the interrupt master gate
    q_nxt.wake = dsp_port && wake_pend;

    // attention indicator drive
    // counter restarts outside blink: full first half
    if (q_r.ctl.attn_ind_ctl == hpsc_pkg::ATTN_BLINK) begin
      if (q_r.blink_cnt >= 32'(BLINK_HALF_CYC - 1)) begin
        q_nxt.blink_cnt = 32'h0000_0000;
        q_nxt.led       = !q_r.led;
      end else begin
        q_nxt.blink_cnt = q_r.blink_cnt + 32'h0000_0001;
      end
    end else begin
      q_nxt.blink_cnt = 32'h0000_0000;
      q_nxt.led       = (q_r.ctl.attn_ind_ctl == hpsc_pkg::ATTN_ON);
    end

    // readies are registered and fall as soon as a slot is occupied
    // from the next state, so a ready is never stale
    q_nxt.awready = !q_nxt.aw_full && !q_nxt.bvalid;
    q_nxt.wready  = !q_nxt.w_full && !q_nxt.bvalid;
    q_nxt.arready = !q_nxt.rvalid;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  // synchronous reset; readies come up open
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r           <= '0;
      q_r.awready   <= 1'b1;
      q_r.wready    <= 1'b1;
      q_r.arready   <= 1'b1;
      q_r.cap       <= hpsc_pkg::hpsc_cap_t'(hpsc_pkg::CAP_RST);
      q_r.ctl       <= hpsc_pkg::hpsc_ctl_t'(hpsc_pkg::CTL_RST);
      q_r.sts       <= hpsc_pkg::hpsc_sts_t'(hpsc_pkg::STS_RST);
    end else begin
      q_r <= q_nxt;
    end
  end

  // ------------------------------------------------------------------
  // message requests
  // ------------------------------------------------------------------
  // power limit message carries the fields as they stand after the write
  hpsc_msg_slot #(
    .W (10)
  ) u_spl_msg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .send    (q_r.spl_send),
    .payload ({q_r.cap.spl_scale, q_r.cap.spl_value}),
    .ready   (spl_msg_ready),
    .valid   (spl_msg_valid),
    .data    (spl_msg)
  );

  // attention indicator message carries the new code
  // code 00 is never sent: only on, blink or off
  hpsc_msg_slot #(
    .W (2)
  ) u_attn_msg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .send    (q_r.attn_send),
    .payload (q_r.ctl.attn_ind_ctl),
    .ready   (attn_msg_ready),
    .valid   (attn_msg_valid),
    .data    (attn_msg)
  );

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // all outputs come straight from flip-flops
  assign s_axil_awready = q_r.awready;
  assign s_axil_wready  = q_r.wready;
  assign s_axil_bvalid  = q_r.bvalid;
  assign s_axil_bresp   = q_r.bresp;
  assign s_axil_arready = q_r.arready;
  assign s_axil_rvalid  = q_r.rvalid;
  assign s_axil_rresp   = q_r.rresp;
  assign s_axil_rdata   = q_r.rdata;
  assign hp_irq         = q_r.irq;
  assign hp_wake        = q_r.wake;
  assign attn_led       = q_r.led;

endmodule

/* common/hpsc_pkg.sv */
// shared constants and types of the hot-plug slot capability and control registers
package hpsc_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFF_SLOT_CAP = 8'hD4;
  localparam logic [7:0]  OFF_SLOT_CTL = 8'hD8;

  // ------------------------------------------------------------------
  // field layouts
  // ------------------------------------------------------------------
  // slot capabilities word, bit 31 first
  typedef struct packed {
    logic [12:0] slot_num;
    logic [1:0]  rsvd_hi;
    logic [1:0]  spl_scale;
    logic [7:0]  spl_value;
    logic        hp_capable;
    logic        surprise;
    logic        pwr_ind;
    logic        attn_ind;
    logic        rsvd_lo;
    logic        pwr_ctl;
    logic        attn_btn;
  } hpsc_cap_t;

  // slot control half word (bits 15:0 of the control word)
  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [1:0] attn_ind_ctl;
    logic       hp_int_en;
    logic       cc_int_en;
    logic       pdc_en;
    logic       rsvd_b2;
    logic       pfd_en;
    logic       abp_en;
  } hpsc_ctl_t;

  // slot status half word (bits 31:16 of the control word)
  typedef struct packed {
    logic [10:0] rsvd_hi;
    logic        cmd_done;
    logic        pres_chg;
    logic        mrl_chg;
    logic        pwr_fault;
    logic        attn_btn;
  } hpsc_sts_t;

  // hot-plug events, one-cycle pulses from the slot hardware
  typedef struct packed {
    logic cmd_done;
    logic pres_chg;
    logic pwr_fault;
    logic attn_btn;
  } hpsc_evt_t;

  // capability default override from smbus or eeprom autoload
  typedef struct packed {
    logic      valid;
    hpsc_cap_t data;
  } hpsc_ovr_t;

  // set slot power limit message payload
  typedef struct packed {
    logic [1:0] scale;
    logic [7:0] value;
  } hpsc_spl_t;

  // ------------------------------------------------------------------
  // reset values, masks and codes
  // ------------------------------------------------------------------
  localparam logic [31:0] CAP_RST      = 32'h0000_0000;
  localparam logic [15:0] CTL_RST      = 16'h00C0;
  localparam logic [15:0] STS_RST      = 16'h0000;
  localparam logic [31:0] CAP_WR_MASK  = 32'h0001_FF80;
  localparam logic [31:0] CAP_RD_MASK  = 32'hFFF9_FFFB;
  localparam logic [15:0] CTL_EN_MASK  = 16'h003B;
  localparam logic [15:0] STS_W1C_MASK = 16'h001B;
  localparam logic [1:0]  ATTN_RSVD    = 2'h0;
  localparam logic [1:0]  ATTN_ON      = 2'h1;
  localparam logic [1:0]  ATTN_BLINK   = 2'h2;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_KHZ        = 50000;
  localparam int unsigned BLINK_HALF_MS  = 500;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;

endpackage

/* rtl/hpsc_ovr_load.sv */
// capability default loader fed by smbus writes and eeprom autoload
`timescale 1ns/1ps
module hpsc_ovr_load (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire hpsc_pkg::hpsc_ovr_t smbus_ovr,
  input  wire hpsc_pkg::hpsc_ovr_t eeprom_ovr,
  output hpsc_pkg::hpsc_cap_t      cap_dflt,
  output logic                     load
);

  typedef struct packed {
    hpsc_pkg::hpsc_cap_t dflt;
    logic                load;
  } hpsc_ovr_st_t;

  hpsc_ovr_st_t q_r;
  hpsc_ovr_st_t q_nxt;

  // smbus wins a tie: it is the later, deliberate override
  always_comb begin
    q_nxt      = q_r;
    q_nxt.load = 1'b0;
    if (smbus_ovr.valid) begin
      q_nxt.dflt = hpsc_pkg::hpsc_cap_t'(smbus_ovr.data & hpsc_pkg::CAP_RD_MASK);
      q_nxt.load = 1'b1;
    end else if (eeprom_ovr.valid) begin
      q_nxt.dflt = hpsc_pkg::hpsc_cap_t'(eeprom_ovr.data & hpsc_pkg::CAP_RD_MASK);
      q_nxt.load = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r.dflt <= hpsc_pkg::hpsc_cap_t'(hpsc_pkg::CAP_RST);
      q_r.load <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign cap_dflt = q_r.dflt;
  assign load     = q_r.load;

endmodule

/* rtl/hpsc_msg_slot.sv */
// one-deep holder for an outgoing message request with valid and ready
`timescale 1ns/1ps
module hpsc_msg_slot #(
  parameter int unsigned W = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         send,
  input  wire logic [W-1:0] payload,
  input  wire logic         ready,
  output logic              valid,
  output logic [W-1:0]      data
);

  if (W < 1) begin : g_chk
    $error("hpsc_msg_slot: payload width must be at least one");
  end

  typedef struct packed {
    logic         valid;
    logic [W-1:0] data;
  } hpsc_msg_st_t;

  hpsc_msg_st_t q_r;
  hpsc_msg_st_t q_nxt;

  // a new request replaces a pending one: only the latest setting matters
  always_comb begin
    q_nxt = q_r;
    if (q_r.valid && ready) begin
      q_nxt.valid = 1'b0;
    end
    if (send) begin
      q_nxt.valid = 1'b1;
      q_nxt.data  = payload;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign valid = q_r.valid;
  assign data  = q_r.data;

endmodule

/* tb/hpsc_props.sv */
// assertion checker for the slot capability and control block
`timescale 1ns/1ps
module hpsc_props #(
  parameter int unsigned BLINK_HALF_CYC = 4
) (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic [hpsc_pkg::ADDR_W-1:0] s_axil_araddr,
  input wire logic                        s_axil_arvalid,
  input wire logic                        s_axil_arready,
  input wire logic [1:0]                  s_axil_bresp,
  input wire logic                        s_axil_bvalid,
  input wire logic [31:0]                 s_axil_rdata,
  input wire logic [1:0]                  s_axil_rresp,
  input wire logic                        s_axil_rvalid,
  input wire logic                        dsp_port,
  input wire logic                        hp_irq,
  input wire logic                        hp_wake,
  input wire logic                        spl_msg_valid,
  input wire logic                        spl_msg_ready,
  input wire logic                        attn_msg_valid,
  input wire logic [1:0]                  attn_msg,
  input wire logic                        attn_msg_ready
);
  logic [7:0] ar_addr_r;
  // ------------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------------
  // remember the read address so the answer can be judged by register
  always_ff @(posedge aclk) begin
    if (s_axil_arvalid && s_axil_arready) begin
      ar_addr_r <= s_axil_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  AST_NODSP_IRQ: assert property (!dsp_port ##1 !dsp_port |-> !hp_irq && !hp_wake)
    else $error("slot event output while port is not downstream");
  AST_NODSP_WR: assert property (!dsp_port [*3] ##0 s_axil_bvalid |->
    s_axil_bresp == hpsc_pkg::RESP_SLVERR) else $error("write accepted on upstream port");
  AST_NODSP_RD: assert property (!dsp_port [*3] ##0 s_axil_rvalid |->
    s_axil_rdata == 32'h0 && s_axil_rresp == hpsc_pkg::RESP_SLVERR)
    else $error("read answered on upstream port");
  AST_SPL_RISE: assert property ($rose(spl_msg_valid) |->
    $past(s_axil_bvalid) && !$past(s_axil_bvalid, 2)) else $error("power limit message untimely");
  AST_SPL_HOLD: assert property (spl_msg_valid && !spl_msg_ready |=> spl_msg_valid)
    else $error("power limit message dropped");
  AST_ATTN_RISE: assert property ($rose(attn_msg_valid) |->
    $past(s_axil_bvalid) && !$past(s_axil_bvalid, 2)) else $error("indicator message untimely");
  AST_ATTN_HOLD: assert property (attn_msg_valid && !attn_msg_ready |=>
    attn_msg_valid && $stable(attn_msg)) else $error("indicator message dropped");
  AST_ATTN_CODE: assert property (attn_msg_valid |-> attn_msg != hpsc_pkg::ATTN_RSVD)
    else $error("reserved indicator code sent");
  AST_CAP_RSVD: assert property (s_axil_rvalid && ar_addr_r[7:2] == 6'h35 |->
    (s_axil_rdata & ~hpsc_pkg::CAP_RD_MASK) == 32'h0) else $error("capability reserved set");
  AST_CTL_RSVD: assert property (s_axil_rvalid && ar_addr_r[7:2] == 6'h36 |->
    (s_axil_rdata & 32'hFFE4_FF04) == 32'h0) else $error("control reserved bit set");
endmodule
bind hpsc_top hpsc_props #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_props (.aclk, .aresetn,
  .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_bresp, .s_axil_bvalid,
  .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .dsp_port, .hp_irq, .hp_wake,
  .spl_msg_valid, .spl_msg_ready, .attn_msg_valid, .attn_msg, .attn_msg_ready);

/* tb/hpsc_slot_model.sv */
// slot hardware model: hot-plug event pulses and message receiver
`timescale 1ns/1ps
module hpsc_slot_model (
  input  wire logic                aclk,
  input  wire logic                stall,
  input  wire logic                spl_msg_valid,
  input  wire hpsc_pkg::hpsc_spl_t spl_msg,
  output logic                     spl_msg_ready,
  input  wire logic                attn_msg_valid,
  input  wire logic [1:0]          attn_msg,
  output logic                     attn_msg_ready,
  output hpsc_pkg::hpsc_evt_t      hp_evt
);
  int                  n_spl = 0;
  int                  n_attn = 0;
  hpsc_pkg::hpsc_spl_t last_spl = '0;
  logic [1:0]          last_attn = 2'h0;
  initial hp_evt = '0;
  // a stalled receiver shows that pending messages are held, not lost
  assign spl_msg_ready  = !stall;
  assign attn_msg_ready = !stall;
  // count every accepted message and keep its payload
  always @(posedge aclk) begin
    if (spl_msg_valid && spl_msg_ready) begin
      n_spl <= n_spl + 1;
      last_spl <= spl_msg;
    end
    if (attn_msg_valid && attn_msg_ready) begin
      n_attn <= n_attn + 1;
      last_attn <= attn_msg;
    end
  end
  // one-cycle event pulse, entered right after a rising edge
  task automatic pulse(input hpsc_pkg::hpsc_evt_t e);
    hp_evt <= e;
    @(posedge aclk);
    hp_evt <= '0;
  endtask
endmodule

/* tb/tb_hpsc_top.sv */
// self-checking bench for the slot capability and control registers
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_hpsc_top;
  localparam logic [1:0] OK = hpsc_pkg::RESP_OKAY;
  localparam logic [1:0] ER = hpsc_pkg::RESP_SLVERR;
  localparam logic [7:0] CAP = hpsc_pkg::OFF_SLOT_CAP;
  localparam logic [7:0] CTL = hpsc_pkg::OFF_SLOT_CTL;
  int                  errors = 0;
  int                  checks = 0;
  logic                aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dsp_port;
  logic                stall, awready, wready, bvalid, arready, rvalid, v;
  logic                hp_irq, hp_wake, attn_led, spl_v, spl_r, attn_v, attn_r;
  logic [7:0]          awaddr, araddr;
  logic [31:0]         wdata, rdata;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp, attn_msg;
  hpsc_pkg::hpsc_ovr_t smbus_ovr, eeprom_ovr;
  hpsc_pkg::hpsc_evt_t hp_evt;
  hpsc_pkg::hpsc_spl_t spl_msg;
  hpsc_top #(.BLINK_HALF_CYC(4)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
    .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready), .dsp_port(dsp_port),
    .smbus_ovr(smbus_ovr), .eeprom_ovr(eeprom_ovr), .hp_evt(hp_evt), .hp_irq(hp_irq),
    .hp_wake(hp_wake), .attn_led(attn_led), .spl_msg_valid(spl_v), .spl_msg(spl_msg),
    .spl_msg_ready(spl_r), .attn_msg_valid(attn_v), .attn_msg(attn_msg),
    .attn_msg_ready(attn_r));
  hpsc_slot_model slot (.aclk(aclk), .stall(stall), .spl_msg_valid(spl_v),
    .spl_msg(spl_msg), .spl_msg_ready(spl_r), .attn_msg_valid(attn_v),
    .attn_msg(attn_msg), .attn_msg_ready(attn_r), .hp_evt(hp_evt));
  // ------------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------------
  // handshakes are judged at the falling edge, acted on at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] re);
    logic ta, tw, b;
    logic [1:0] r;
    b = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!b) begin
      @(negedge aclk);
      {ta, tw, b, r} = {awvalid && awready, wvalid && wready, bvalid, bresp};
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    `CHK(r, re)
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    logic t, b;
    logic [31:0] d;
    logic [1:0] r;
    b = 1'b0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!b) begin
      @(negedge aclk);
      {t, b, d, r} = {arvalid && arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    `CHK(d, e)
    `CHK(r, re)
  endtask
  // wait whole cycles, then settle at the falling edge for sampling
  task automatic w8(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // clock, watchdog and tests
  // ------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    stop_test();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, stall} = '0;
    {awaddr, araddr, wdata, wstrb, smbus_ovr, eeprom_ovr} = '0;
    dsp_port = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(CAP, 32'h0, OK);
    rdc(CTL, 32'hC0, OK);
    @(posedge aclk);
    stall <= 1'b1;
    wr(CAP, 32'hFFFF_FFFF, 4'hF, OK);
    wr(CTL, 32'h7F, 4'h1, OK);
    w8(2);
    `CHK(spl_v, 1'b1)
    `CHK(slot.n_spl, 0)
    @(posedge aclk);
    stall <= 1'b0;
    w8(2);
    `CHK(slot.n_spl, 1)
    `CHK(slot.last_spl, 10'h3FF)
    `CHK(slot.last_attn, hpsc_pkg::ATTN_ON)
    `CHK(attn_led, 1'b1)
    rdc(CAP, 32'h0001_FF80, OK);
    wr(CTL, 32'h3F, 4'h1, OK);
    rdc(CTL, 32'h7B, OK);
    wr(CTL, 32'hBB, 4'h1, OK);
    w8(4);
    v = attn_led;
    w8(4);
    `CHK(attn_led, !v)
    @(posedge aclk);
    slot.pulse(4'h8);
    w8(3);
    `CHK(hp_irq, 1'b1)
    rdc(CTL, 32'h0010_00BB, OK);
    wr(CTL, 32'h0010_0000, 4'h4, OK);
    w8(3);
    `CHK(hp_irq, 1'b0)
    wr(CTL, 32'h9B, 4'h1, OK);
    @(posedge aclk);
    slot.pulse(4'h7);
    w8(3);
    `CHK(hp_irq, 1'b0)
    `CHK(hp_wake, 1'b1)
    rdc(CTL, 32'h000B_009B, OK);
    `CHK(slot.n_attn, 3)
    @(posedge aclk);
    smbus_ovr <= {1'b1, 32'hFFFF_FFFF};
    @(posedge aclk);
    smbus_ovr <= '0;
    w8(3);
    rdc(CAP, 32'hFFF9_FFFB, OK);
    @(posedge aclk);
    eeprom_ovr <= {1'b1, 32'h0000_0009};
    @(posedge aclk);
    eeprom_ovr <= '0;
    w8(3);
    rdc(CAP, 32'h0000_0009, OK);
    rdc(8'h10, 32'h0, ER);
    @(posedge aclk);
    dsp_port <= 1'b0;
    rdc(CAP, 32'h0, ER);
    wr(CAP, 32'h80, 4'hF, ER);
    w8(4);
    `CHK(slot.n_spl, 1)
    stop_test();
  end
endmodule
